// ### verilog/adcro_readout.sv
// result readout port: parallel, byte and serial delivery of eight results
`timescale 1ns/10ps
`default_nettype none
`include "adcro_map.svh"
module adcro_readout #(
  parameter int NUM_CH     = `ADCRO_NUM_CH,
  parameter int WORD_W     = `ADCRO_WORD_W,
  parameter int FIFO_DEPTH = `ADCRO_FIFO_DEPTH
) (
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_BUSY,
  input  wire logic              I_RES_VALID,
  input  wire logic [WORD_W-1:0] I_RES_DATA,
  output var  logic              O_RES_READY,
  input  wire logic              I_CS_N,
  input  wire logic              I_RD_N,
  input  wire logic              I_SCLK,
  input  wire logic              I_INTERFACE_SELECT,
  input  wire logic              I_BYTE_SERIAL_SELECT,
  input  wire logic              I_BYTE_ORDER_PIN,
  output var  logic              O_BUSY,
  output var  logic [15:0]       O_PARALLEL_RESULT_BUS,
  output var  logic              O_HIGH_LANES_OE,
  output var  logic              O_LOW_BYTE_LANES_OE,
  output var  logic              O_SERIAL_LINE_A,
  output var  logic              O_SERIAL_LINE_A_OE,
  output var  logic              O_SERIAL_LINE_B,
  output var  logic              O_SERIAL_LINE_B_OE,
  output var  logic              O_FIRST_CHANNEL_FLAG,
  output var  logic              O_FIRST_CHANNEL_FLAG_OE
);
  import adcro_pkg::*;

  localparam int CH_W = $clog2(NUM_CH);
  localparam int SB_W = $clog2(`ADCRO_SER_BITS);

  // pin synchronisers: {cs, rd, sclk, ifsel, bssel, order}
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [2:0] sy3;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sy1 <= 6'h3F;
      sy2 <= 6'h3F;
      sy3 <= 3'h7;
    end else begin
      sy1 <= {I_CS_N, I_RD_N, I_SCLK, I_INTERFACE_SELECT, I_BYTE_SERIAL_SELECT, I_BYTE_ORDER_PIN};
      sy2 <= sy1;
      sy3 <= sy2[5:3];
    end
  end

  wire cs_low    = ~sy2[5];
  wire cs_fall   = sy3[2] & ~sy2[5];
  wire cs_rise   = ~sy3[2] & sy2[5];
  wire rd_fall   = sy3[1] & ~sy2[4] & cs_low;
  wire sclk_rise = ~sy3[0] & sy2[3] & cs_low;
  wire sclk_fall = sy3[0] & ~sy2[3] & cs_low;
  wire order_hi  = sy2[0];

  // mode decode
  adcro_mode_t mode;
  adcro_mode_t next_mode;
  assign next_mode = ~sy2[2] ? ADCRO_PAR : (sy2[1] ? ADCRO_BYTE : ADCRO_SER);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      mode <= ADCRO_PAR;
    end else begin
      mode <= next_mode;
    end
  end

  wire is_par  = (mode == ADCRO_PAR);
  wire is_byte = (mode == ADCRO_BYTE);
  wire is_ser  = (mode == ADCRO_SER);

  // result path: fifo -> staging -> output registers at busy fall
  logic              busy_q;
  wire               busy_fall = busy_q & ~I_BUSY;
  logic [WORD_W-1:0] stage [NUM_CH];
  logic [WORD_W-1:0] res   [NUM_CH];
  logic [CH_W:0]     stage_cnt;
  logic              f_valid;
  logic [WORD_W-1:0] f_data;
  // staging stalls once a full sample waits, which backs up the fifo
  wire               drain = (stage_cnt < (CH_W+1)'(NUM_CH)) & ~busy_fall;

  adcro_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CORE_CLK),
    .i_rst       (I_RST),
    .i_in_valid  (I_RES_VALID),
    .i_in_data   (I_RES_DATA),
    .o_in_ready  (O_RES_READY),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (drain)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      busy_q    <= 1'b0;
      stage_cnt <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        res[i]   <= `ADCRO_RESET_WORD;
        stage[i] <= `ADCRO_RESET_WORD;
      end
    end else begin
      busy_q <= I_BUSY;
      if (busy_fall) begin
        res       <= stage;
        stage_cnt <= '0;
      end else if (f_valid & drain) begin
        stage[stage_cnt[CH_W-1:0]] <= f_data;
        stage_cnt                  <= stage_cnt + 1'b1;
      end
    end
  end

  // read position, shared by parallel and byte modes; restarts with each sample
  logic [CH_W:0]     pos;
  logic [CH_W-1:0]   slot;
  logic [SB_W-1:0]   bit_cnt;
  logic              need_load;
  logic [WORD_W-1:0] sh_a;
  logic [WORD_W-1:0] sh_b;
  adcro_drv_t        drv;

  wire [CH_W-1:0]   par_ch   = pos[CH_W-1:0];
  wire [CH_W-1:0]   byte_ch  = pos[CH_W:1];
  wire              first_bt = ~pos[0];
  wire [WORD_W-1:0] byte_wd  = res[byte_ch];
  wire              upper    = ~(first_bt ^ order_hi);
  wire [7:0]        byte_out = upper ? byte_wd[15:8] : byte_wd[7:0];
  wire [CH_W-1:0]   slot_b   = slot ^ CH_W'(`ADCRO_SET_B_OFS);
  wire              last_bit = (bit_cnt == SB_W'(`ADCRO_SER_BITS - 1));

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      pos <= '0;
      drv <= '0;
    end else begin
      drv.busy    <= I_BUSY;
      drv.hi_oe   <= is_par & cs_low;
      drv.lo_oe   <= (is_par | is_byte) & cs_low;
      drv.ser_oe  <= is_ser & cs_low;
      drv.flag_oe <= cs_low;
      if (busy_fall) begin
        pos <= '0;
      end else if (rd_fall & is_par) begin
        drv.bus  <= res[par_ch];
        drv.flag <= (par_ch == '0);
        pos      <= {1'b0, CH_W'(par_ch + 1'b1)};
      end else if (rd_fall & is_byte) begin
        drv.bus  <= {8'h00, byte_out};
        drv.flag <= (byte_ch == '0);
        pos      <= pos + 1'b1;
      end else if (is_ser & cs_fall) begin
        drv.flag <= (slot == '0);
      end else if (is_ser & sclk_fall & last_bit) begin
        drv.flag <= 1'b0;
      end else if (is_ser & sclk_rise & need_load) begin
        drv.flag <= (slot == '0);
      end
    end
  end

  // serial shifter: msb shows at select fall, rest on rising clock edges
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      slot      <= '0;
      bit_cnt   <= '0;
      need_load <= 1'b0;
      sh_a      <= '0;
      sh_b      <= '0;
    end else if (busy_fall) begin
      slot      <= '0;
      bit_cnt   <= '0;
      need_load <= 1'b0;
    end else if (is_ser) begin
      if (cs_fall) begin
        sh_a      <= res[slot];
        sh_b      <= res[slot_b];
        bit_cnt   <= '0;
        need_load <= 1'b0;
      end else if (sclk_fall) begin
        if (last_bit) begin
          bit_cnt   <= '0;
          slot      <= slot + 1'b1;
          need_load <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 1'b1;
        end
      end else if (sclk_rise) begin
        if (need_load) begin
          sh_a      <= res[slot];
          sh_b      <= res[slot_b];
          need_load <= 1'b0;
        end else begin
          sh_a <= {sh_a[WORD_W-2:0], 1'b0};
          sh_b <= {sh_b[WORD_W-2:0], 1'b0};
        end
      end
    end
  end

  // a frame that ends mid-word restarts that channel at the next select fall
  assign O_BUSY                  = drv.busy;
  assign O_PARALLEL_RESULT_BUS   = drv.bus;
  assign O_HIGH_LANES_OE         = drv.hi_oe;
  assign O_LOW_BYTE_LANES_OE     = drv.lo_oe;
  assign O_SERIAL_LINE_A         = sh_a[WORD_W-1];
  assign O_SERIAL_LINE_B         = sh_b[WORD_W-1];
  assign O_SERIAL_LINE_A_OE      = drv.ser_oe;
  assign O_SERIAL_LINE_B_OE      = drv.ser_oe;
  assign O_FIRST_CHANNEL_FLAG    = drv.flag;
  assign O_FIRST_CHANNEL_FLAG_OE = drv.flag_oe;

  // the host must finish reading before busy falls; a read at that edge loses
  // to the reload and restarts the sequence

  property p_commit;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      busy_fall |=> (res[0] == $past(stage[0])) && (res[NUM_CH-1] == $past(stage[NUM_CH-1]));
  endproperty
  a_commit: assert property (p_commit) else $error("results not loaded at busy fall");

  property p_hold;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (busy_q & I_BUSY) |=> (res[0] == $past(res[0]));
  endproperty
  a_hold: assert property (p_hold) else $error("results changed while busy");

  property p_busy;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      $fell(I_BUSY) |=> !O_BUSY ##0 (res[1] == $past(stage[1]));
  endproperty
  a_busy: assert property (p_busy) else $error("busy and results out of step");

  property p_mode;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (sy2[2] & ~sy2[1]) |=> (mode == ADCRO_SER);
  endproperty
  a_mode: assert property (p_mode) else $error("serial mode not selected");

  property p_bus_oe;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_par & cs_fall & (next_mode == ADCRO_PAR)) |=> O_HIGH_LANES_OE && O_LOW_BYTE_LANES_OE;
  endproperty
  a_bus_oe: assert property (p_bus_oe) else $error("bus not driven after select fall");

  property p_first_par;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_par & rd_fall & ~busy_fall & (pos == '0)) |=> O_FIRST_CHANNEL_FLAG && (O_PARALLEL_RESULT_BUS == res[0]);
  endproperty
  a_first_par: assert property (p_first_par) else $error("channel one not first");

  property p_flag_off;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      cs_rise |=> !O_FIRST_CHANNEL_FLAG_OE && !O_SERIAL_LINE_A_OE;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("outputs still driven after select rise");

  property p_byte_flag;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_byte & rd_fall & ~busy_fall & (pos == (CH_W+1)'(2))) |=> !O_FIRST_CHANNEL_FLAG;
  endproperty
  a_byte_flag: assert property (p_byte_flag) else $error("flag high on third byte read");

  property p_byte_order;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_byte & rd_fall & ~busy_fall & (pos == '0) & order_hi) |=> (O_PARALLEL_RESULT_BUS[7:0] == res[0][15:8]);
  endproperty
  a_byte_order: assert property (p_byte_order) else $error("upper byte not first");

  property p_ser_msb;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_ser & cs_fall & ~busy_fall & (slot == '0)) |=> O_SERIAL_LINE_A == res[0][WORD_W-1]
        && O_SERIAL_LINE_B == res[`ADCRO_SET_B_OFS][WORD_W-1] && O_FIRST_CHANNEL_FLAG;
  endproperty
  a_ser_msb: assert property (p_ser_msb) else $error("serial msb or flag wrong at select fall");

  property p_ser_end;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_ser & sclk_fall & last_bit & ~busy_fall) |=> !O_FIRST_CHANNEL_FLAG ##0 need_load;
  endproperty
  a_ser_end: assert property (p_ser_end) else $error("flag not low after sixteenth bit");

  property p_par_later;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_par & rd_fall & ~busy_fall & (pos != '0)) |=> !O_FIRST_CHANNEL_FLAG;
  endproperty
  a_par_later: assert property (p_par_later) else $error("flag high after channel one");

  property p_line_b_wrap;
    @(posedge I_CORE_CLK) disable iff (I_RST)
      (is_ser & cs_fall & ~busy_fall & (slot == CH_W'(`ADCRO_SET_B_OFS))) |=> O_SERIAL_LINE_B == res[0][WORD_W-1];
  endproperty
  a_line_b_wrap: assert property (p_line_b_wrap) else $error("line b not back at channel one");
endmodule // adcro_readout
`default_nettype wire

// ### verilog/adcro_map.svh
// constants for the converter result readout port
`ifndef ADCRO_MAP_SVH
`define ADCRO_MAP_SVH
`define ADCRO_NUM_CH     8
`define ADCRO_WORD_W     16
`define ADCRO_SER_BITS   16
`define ADCRO_FIFO_DEPTH 4
`define ADCRO_SET_B_OFS  4
`define ADCRO_RESET_WORD 16'h0000
`define ADCRO_MODE_PAR   3'h1
`define ADCRO_MODE_BYTE  3'h2
`define ADCRO_MODE_SER   3'h4
`endif

// ### verilog/adcro_pkg.sv
// types shared by the result readout port
`include "adcro_map.svh"
package adcro_pkg;
  typedef enum logic [2:0] {
    ADCRO_PAR  = `ADCRO_MODE_PAR,
    ADCRO_BYTE = `ADCRO_MODE_BYTE,
    ADCRO_SER  = `ADCRO_MODE_SER
  } adcro_mode_t;

  typedef struct packed {
    logic [15:0] bus;
    logic        hi_oe;
    logic        lo_oe;
    logic        ser_oe;
    logic        flag;
    logic        flag_oe;
    logic        busy;
  } adcro_drv_t;
endpackage

// ### verilog/adcro_fifo.sv
// small result fifo between conversion engine and staging registers
`timescale 1ns/10ps
`default_nettype none
module adcro_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output var  logic             o_in_ready,
  output var  logic             o_out_valid,
  output var  logic [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  wire              push = i_in_valid & o_in_ready;
  wire              pop  = o_out_valid & i_out_ready;

  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      o_in_ready <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr      <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count      <= next_count;
      // registered ready keeps the source path short
      o_in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule // adcro_fifo
`default_nettype wire

// ### verification/adcro_host.sv
// host model driving the readout pins and sampling the results
`timescale 1ns/10ps
`default_nettype none
module adcro_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_bus,
  input  wire logic [2:0]  i_oe,
  input  wire logic        i_line_a,
  input  wire logic        i_line_b,
  input  wire logic        i_flag,
  output var  logic        o_cs_n,
  output var  logic        o_rd_n,
  output var  logic        o_sclk
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_sclk = 1'b1;
  end
  // four cycles per level: pins pass a 2-ff sync plus one cycle
  task automatic hold(input int n);
    repeat (n) @(posedge i_clk) #1;
  endtask
  task automatic sel(input logic v);
    o_cs_n = v;
    hold(4);
  endtask
  // data and flags taken before the strobe is released
  task automatic strobe(input logic tied, output logic [15:0] d, output logic [3:0] g);
    o_rd_n = 1'b0;
    if (tied) o_cs_n = 1'b0;
    hold(4);
    d = i_bus;
    g = {i_oe, i_flag};
    o_rd_n = 1'b1;
    if (tied) o_cs_n = 1'b1;
    hold(4);
  endtask
  // sixteen clocks idling high: bit taken as sclk falls, next bit shifts on the rise
  task automatic word(output logic [15:0] a, output logic [15:0] b, output logic [15:0] f);
    for (int i = 15; i >= 0; i--) begin
      a[i] = i_line_a;
      b[i] = i_line_b;
      f[i] = i_flag;
      o_sclk = 1'b0;
      hold(4);
      o_sclk = 1'b1;
      hold(4);
    end
  endtask
endmodule // adcro_host
`default_nettype wire

// ### verification/adcro_readout_test.sv
// self-checking bench for the result readout port
`timescale 1ns/10ps
`default_nettype none
module adcro_readout_test;
  import adcro_pkg::*;
  logic        clk, rst, busy, vld;
  logic        isel, bsel, ord;
  logic [15:0] dat;
  logic [15:0] d, a, b, f, x;
  logic [3:0]  g;
  wire         cs_n, rd_n, sclk, ready, obusy, hoe, loe, sa, saoe, sb, sboe, flag, foe;
  wire  [15:0] bus;
  int          n_mismatch = 0;
  int          samples_checked = 0;

  always #50 clk = ~clk;

  adcro_readout uut (
    .I_CORE_CLK(clk), .I_RST(rst), .I_BUSY(busy), .I_RES_VALID(vld), .I_RES_DATA(dat), .O_RES_READY(ready),
    .I_CS_N(cs_n), .I_RD_N(rd_n), .I_SCLK(sclk), .I_INTERFACE_SELECT(isel), .I_BYTE_SERIAL_SELECT(bsel),
    .I_BYTE_ORDER_PIN(ord), .O_BUSY(obusy), .O_PARALLEL_RESULT_BUS(bus), .O_HIGH_LANES_OE(hoe),
    .O_LOW_BYTE_LANES_OE(loe), .O_SERIAL_LINE_A(sa), .O_SERIAL_LINE_A_OE(saoe), .O_SERIAL_LINE_B(sb),
    .O_SERIAL_LINE_B_OE(sboe), .O_FIRST_CHANNEL_FLAG(flag), .O_FIRST_CHANNEL_FLAG_OE(foe)
  );
  adcro_host host (
    .i_clk(clk), .i_bus(bus), .i_oe({hoe, loe, foe}), .i_line_a(sa), .i_line_b(sb), .i_flag(flag),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_sclk(sclk)
  );

  // word k of the stream: sample k/8+1, channel k%8
  function automatic logic [15:0] wv(input int s, input int c);
    return 16'h1000 * 16'(s) + 16'h0111 * 16'(c) + 16'h0805;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // valid held across the run of words; a word is taken where ready is high
  task automatic push(input int k0, input int k1);
    int t;
    for (int k = k0; k <= k1; k++) begin
      vld = 1'b1;
      dat = wv(k / 8 + 1, k % 8);
      t = 0;
      while (ready !== 1'b1 && t < 200) begin
        step(1);
        t++;
      end
      if (t == 200) n_mismatch++;
      step(1);
    end
    vld = 1'b0;
  endtask
  task automatic conv(input int k0, input int k1);
    busy = 1'b1;
    step(2);
    check("busy out", {15'h0, obusy}, 16'h0001);
    push(k0, k1);
    step(4);
    busy = 1'b0;
    step(2);
    check("busy out", {15'h0, obusy}, 16'h0000);
  endtask

  initial begin
    clk  = 1'b0;
    rst  = 1'b1;
    busy = 1'b0;
    vld  = 1'b0;
    isel = 1'b0;
    bsel = 1'b0;
    ord  = 1'b0;
    dat  = 16'h0000;
    step(8);
    rst = 1'b0;
    step(6);
    check("ready", {15'h0, ready}, 16'h0001);
    check("drive", {11'h0, hoe, loe, foe, saoe, sboe}, 16'h0000);
    endt("reset");
    conv(0, 7);
    for (int m = 0; m < 2; m++) begin
      bsel = m[0];
      step(4);
      if (m == 1) host.sel(1'b0);
      for (int c = 0; c < 8; c++) begin
        host.strobe(m == 0, d, g);
        check("par data", d, wv(1, c));
        check("par flags", {12'h0, g}, c == 0 ? 16'h000F : 16'h000E);
      end
      if (m == 1) host.sel(1'b1);
      check("par release", {13'h0, hoe, loe, foe}, 16'h0000);
    end
    endt("parallel");
    busy = 1'b1;
    push(8, 19);
    step(4);
    check("ready full", {15'h0, ready}, 16'h0000);
    isel = 1'b1;
    bsel = 1'b1;
    for (int o = 1; o >= 0; o--) begin
      ord = o[0];
      step(4);
      host.sel(1'b0);
      for (int r = 0; r < 16; r++) begin
        host.strobe(1'b0, d, g);
        x = wv(1, r / 2);
        check("byte data", d, {8'h00, ((r % 2 == 0) == (o == 1)) ? x[15:8] : x[7:0]});
        check("byte flags", {12'h0, g}, r < 2 ? 16'h0007 : 16'h0006);
      end
      host.sel(1'b1);
    end
    busy = 1'b0;
    step(2);
    push(20, 23);
    endt("byte");
    bsel = 1'b0;
    step(4);
    host.word(a, b, f);
    check("idle drive", {13'h0, saoe, sboe, foe}, 16'h0000);
    host.sel(1'b0);
    check("ser drive", {13'h0, saoe, sboe, foe}, 16'h0007);
    for (int n = 0; n < 4; n++) begin
      host.word(a, b, f);
      check("line a", a, wv(2, n));
      check("line b", b, wv(2, n + 4));
      check("ser flag", f, n == 0 ? 16'hFFFF : 16'h0000);
      check("flag end", {15'h0, flag}, 16'h0000);
    end
    host.sel(1'b1);
    endt("serial both");
    conv(24, 23);
    for (int n = 0; n < 8; n++) begin
      host.sel(1'b0);
      host.word(a, b, f);
      host.sel(1'b1);
      check("line a", a, wv(3, n));
      check("line b", b, wv(3, (n + 4) % 8));
      check("ser flag", f, n == 0 ? 16'hFFFF : 16'h0000);
    end
    endt("serial framed");
    close_out;
  end

  // run needs about 2200 cycles; cut off well beyond
  initial begin
    #2000000;
    n_mismatch++;
    close_out;
  end
endmodule // adcro_readout_test
`default_nettype wire
